// >>> afc_pkg.sv
/*
 * Shared constants and types for the cache-flush and error-posting command
 * slice of a disk controller. Assumes the host reaches the command block
 * registers at their I/O addresses 0x1f1 to 0x1f7.
 */
package afc_pkg;

   // ==========================================================
   // Command block addresses
   localparam int          ADDR_W     = 10;
   localparam logic [9:0]  A_ERR_FEAT = 10'h1f1;
   localparam logic [9:0]  A_COUNT    = 10'h1f2;
   localparam logic [9:0]  A_SECTOR   = 10'h1f3;
   localparam logic [9:0]  A_CYL_LO   = 10'h1f4;
   localparam logic [9:0]  A_CYL_HI   = 10'h1f5;
   localparam logic [9:0]  A_DEV_HEAD = 10'h1f6;
   localparam logic [9:0]  A_CMD_STAT = 10'h1f7;

   // ==========================================================
   // Field positions
   localparam int ST_BSY    = 7;
   localparam int ST_DRDY   = 6;
   localparam int ST_DWF    = 5;
   localparam int ST_ERR    = 0;
   localparam int ER_ICRC   = 7;
   localparam int ER_UNC    = 6;
   localparam int ER_IDNF   = 4;
   localparam int ER_ABRT   = 2;
   localparam int ER_TR0NF  = 1;
   localparam int DH_SELECT = 4;

   // ==========================================================
   // Reset values
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] RD_IDLE = 8'h00;

   // ==========================================================
   // Command codes
   localparam logic [7:0] C_FLUSH      = 8'he7;
   localparam logic [7:0] C_READ       = 8'h20;
   localparam logic [7:0] C_WRITE      = 8'h30;
   localparam logic [7:0] C_READ_MULT  = 8'hc4;
   localparam logic [7:0] C_WRITE_MULT = 8'hc5;
   localparam logic [7:0] C_READ_DMA   = 8'hc8;
   localparam logic [7:0] C_WRITE_DMA  = 8'hca;
   localparam logic [7:0] C_WRITE_VFY  = 8'h3c;
   localparam logic [7:0] C_READ_VFY   = 8'h40;
   localparam logic [7:0] C_RECAL      = 8'h10;
   localparam logic [7:0] C_SEEK       = 8'h70;
   localparam logic [7:0] C_INIT_PARAM = 8'h91;
   localparam logic [7:0] C_DIAG       = 8'h90;
   localparam logic [7:0] C_FORMAT     = 8'h50;
   localparam logic [7:0] C_READ_LONG  = 8'h22;
   localparam logic [7:0] C_WRITE_LONG = 8'h32;
   localparam logic [7:0] C_SMART      = 8'hb0;

   // ==========================================================
   // Self-monitoring blocks
   localparam int         SM_AW   = 9;
   localparam logic [8:0] SM_LAST = 9'h1ff;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      S_IDLE  = 2'b00,
      S_EXEC  = 2'b01,
      S_FLUSH = 2'b11
   } afc_state_e;

   typedef struct packed {
      logic [7:0] features;
      logic [7:0] count;
      logic [7:0] sector;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] dev_head;
   } afc_taskfile_s;

   typedef struct packed {
      logic              wr;
      logic              sel;
      logic [SM_AW-1:0]  addr;
      logic [7:0]        data;
   } afc_smart_wr_s;

endpackage

// >>> afc_smart_mem.sv
/*
 * Two 512-byte self-monitoring blocks (attribute values, thresholds)
 * with a registered read port. Assumes firmware fills bytes 0..510;
 * the last byte is generated here and writes to it are dropped.
 */
`timescale 1ns/1ps

module afc_smart_mem #(
   parameter int AW = afc_pkg::SM_AW
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   // Firmware fill port
   input  wire afc_pkg::afc_smart_wr_s fill,
   // Host read port
   input  wire logic                  rd,
   input  wire logic                  rd_sel,
   input  wire logic [AW-1:0]         rd_addr,
   output logic      [7:0]            rd_data
);

   localparam int DEPTH = 1 << AW;

   logic [7:0]       mem_q   [2][DEPTH];
   logic [DEPTH-1:0] valid_q [2];
   logic [7:0]       sum_q   [2];
   logic [7:0]       old_byte;
   logic             is_last;

   // Unwritten bytes count as zero so the running sum is defined from reset
   assign old_byte = valid_q[fill.sel][fill.addr] ? mem_q[fill.sel][fill.addr] : 8'h00;
   assign is_last  = (fill.addr == AW'(afc_pkg::SM_LAST));

   // ==========================================================
   // Storage, kept without reset
   always_ff @(posedge clk) begin
      if (fill.wr && !is_last) begin
         mem_q[fill.sel][fill.addr] <= fill.data;
      end
   end

   // ==========================================================
   // Running sum and read port
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         valid_q[0] <= '0;
         valid_q[1] <= '0;
         sum_q[0]   <= 8'h00;
         sum_q[1]   <= 8'h00;
         rd_data    <= afc_pkg::RD_IDLE;
      end else begin
         if (fill.wr && !is_last) begin
            valid_q[fill.sel][fill.addr] <= 1'b1;
            // Incremental update avoids a 511-byte adder at read time
            sum_q[fill.sel] <= 8'(sum_q[fill.sel] + fill.data - old_byte);
         end
         if (rd) begin
            if (rd_addr == AW'(afc_pkg::SM_LAST)) begin
               rd_data <= 8'(~sum_q[rd_sel] + 8'h01);
            end else if (valid_q[rd_sel][rd_addr]) begin
               rd_data <= mem_q[rd_sel][rd_addr];
            end else begin
               rd_data <= 8'h00;
            end
         end
      end
   end

endmodule

// >>> afc_cmd_block.sv
/*
 * Command block register file and command interpreter: cache flush,
 * per-command error posting, ready gating, self-monitoring data blocks.
 * Assumes the host port, media back end and firmware share clk.
 */
`timescale 1ns/1ps

module afc_cmd_block #(
   parameter logic DEV_SEL         = 1'b0,
   parameter logic FLUSH_SUPPORTED = 1'b1
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           sys_rst,
   // Host register port
   input  wire logic [afc_pkg::ADDR_W-1:0]      reg_addr,
   input  wire logic                           reg_wr,
   input  wire logic                           reg_rd,
   input  wire logic [7:0]                     reg_wdata,
   output logic      [7:0]                     reg_rdata,
   output logic                                intrq,
   // Drive condition
   input  wire logic                           drive_ready,
   input  wire logic                           write_fault,
   // General command back end
   output logic                                exec_start,
   output logic      [7:0]                     exec_code,
   output afc_pkg::afc_taskfile_s              task_file,
   input  wire logic                           exec_done,
   input  wire logic [7:0]                     exec_err,
   // Write cache back end
   input  wire logic                           cache_dirty,
   output logic                                flush_start,
   input  wire logic                           flush_done,
   input  wire logic                           flush_fail,
   input  wire logic [7:0]                     flush_err,
   input  wire logic [27:0]                    fail_lba,
   output logic                                cache_drop,
   // Self-monitoring blocks
   input  wire afc_pkg::afc_smart_wr_s         smart_fill,
   input  wire logic                           smart_rd,
   input  wire logic                           smart_sel,
   input  wire logic [afc_pkg::SM_AW-1:0]      smart_addr,
   output logic      [7:0]                     smart_rdata
);

   typedef struct packed {
      afc_pkg::afc_state_e    state;
      afc_pkg::afc_taskfile_s tf;
      logic [7:0]             cmd;
      logic [7:0]             error;
      logic                   err_flag;
      logic                   intrq;
      logic [7:0]             rdata;
      logic                   exec_start;
      logic                   flush_start;
      logic                   cache_drop;
   } afc_core_s;

   afc_core_s  q;
   afc_core_s  d;
   logic       busy;
   logic [8:0] new_info;
   logic [7:0] status;
   logic [8:0] cmd_info;
   logic [8:0] flush_info;

   // ==========================================================
   // Valid error bits per command; bit 8 marks a known code
   function automatic logic [8:0] err_info(input logic [7:0] c);
      logic [7:0] m;
      logic       k;
      m = 8'h00;
      k = 1'b1;
      m[afc_pkg::ER_ABRT] = 1'b1;
      case (c)
         afc_pkg::C_READ_DMA: begin
            m[afc_pkg::ER_ICRC] = 1'b1;
            m[afc_pkg::ER_UNC]  = 1'b1;
            m[afc_pkg::ER_IDNF] = 1'b1;
         end
         afc_pkg::C_WRITE_DMA: begin
            m[afc_pkg::ER_ICRC] = 1'b1;
            m[afc_pkg::ER_IDNF] = 1'b1;
         end
         afc_pkg::C_READ, afc_pkg::C_READ_MULT, afc_pkg::C_WRITE_VFY,
         afc_pkg::C_READ_VFY: begin
            m[afc_pkg::ER_UNC]  = 1'b1;
            m[afc_pkg::ER_IDNF] = 1'b1;
         end
         afc_pkg::C_WRITE, afc_pkg::C_WRITE_MULT, afc_pkg::C_SEEK,
         afc_pkg::C_FORMAT, afc_pkg::C_READ_LONG, afc_pkg::C_WRITE_LONG,
         afc_pkg::C_SMART, afc_pkg::C_FLUSH: begin
            m[afc_pkg::ER_IDNF] = 1'b1;
         end
         afc_pkg::C_RECAL: begin
            m[afc_pkg::ER_TR0NF] = 1'b1;
         end
         // Diagnostic returns its own code, passed through whole
         afc_pkg::C_DIAG: begin
            m = 8'hff;
         end
         8'hc6, 8'hec, 8'hee, 8'hef, 8'he0, 8'he1, 8'he2, 8'he3,
         8'he4, 8'he5, 8'he6, 8'he8, afc_pkg::C_INIT_PARAM: begin
            m = m;
         end
         default: begin
            k = 1'b0;
         end
      endcase
      return {k, m};
   endfunction

   assign busy     = (q.state != afc_pkg::S_IDLE);
   assign new_info = err_info(reg_wdata);
   // Held in nets because a function result cannot be part-selected
   assign cmd_info   = err_info(q.cmd);
   assign flush_info = err_info(afc_pkg::C_FLUSH);

   always_comb begin
      status = 8'h00;
      status[afc_pkg::ST_BSY]  = busy;
      status[afc_pkg::ST_DRDY] = drive_ready;
      status[afc_pkg::ST_DWF]  = write_fault && (q.cmd != afc_pkg::C_DIAG);
      status[afc_pkg::ST_ERR]  = q.err_flag;
   end

   // ==========================================================
   // Next state
   always_comb begin
      d             = q;
      d.exec_start  = 1'b0;
      d.flush_start = 1'b0;
      d.cache_drop  = 1'b0;

      // Host read; a status read acknowledges the interrupt
      if (reg_rd) begin
         if (reg_addr == afc_pkg::A_ERR_FEAT) begin
            d.rdata = q.error;
         end else if (reg_addr == afc_pkg::A_COUNT) begin
            d.rdata = q.tf.count;
         end else if (reg_addr == afc_pkg::A_SECTOR) begin
            d.rdata = q.tf.sector;
         end else if (reg_addr == afc_pkg::A_CYL_LO) begin
            d.rdata = q.tf.cyl_lo;
         end else if (reg_addr == afc_pkg::A_CYL_HI) begin
            d.rdata = q.tf.cyl_hi;
         end else if (reg_addr == afc_pkg::A_DEV_HEAD) begin
            d.rdata = q.tf.dev_head;
         end else if (reg_addr == afc_pkg::A_CMD_STAT) begin
            d.rdata = status;
            d.intrq = 1'b0;
         end else begin
            d.rdata = 8'h00;
         end
      end

      // Writes while busy are dropped; the host is expected to poll first
      if (reg_wr && !busy) begin
         if (reg_addr == afc_pkg::A_ERR_FEAT) begin
            d.tf.features = reg_wdata;
         end else if (reg_addr == afc_pkg::A_COUNT) begin
            d.tf.count = reg_wdata;
         end else if (reg_addr == afc_pkg::A_SECTOR) begin
            d.tf.sector = reg_wdata;
         end else if (reg_addr == afc_pkg::A_CYL_LO) begin
            d.tf.cyl_lo = reg_wdata;
         end else if (reg_addr == afc_pkg::A_CYL_HI) begin
            d.tf.cyl_hi = reg_wdata;
         end else if (reg_addr == afc_pkg::A_DEV_HEAD) begin
            d.tf.dev_head = reg_wdata;
         end else if (reg_addr == afc_pkg::A_CMD_STAT &&
                      q.tf.dev_head[afc_pkg::DH_SELECT] == DEV_SEL) begin
            d.cmd      = reg_wdata;
            d.error    = 8'h00;
            d.err_flag = 1'b0;
            if (!new_info[8] ||
                !(drive_ready || reg_wdata == afc_pkg::C_DIAG ||
                  reg_wdata == afc_pkg::C_INIT_PARAM)) begin
               d.error[afc_pkg::ER_ABRT] = 1'b1;
               d.err_flag = 1'b1;
               d.intrq    = 1'b1;
            end else if (reg_wdata == afc_pkg::C_FLUSH) begin
               if (!FLUSH_SUPPORTED) begin
                  d.error[afc_pkg::ER_ABRT] = 1'b1;
                  d.err_flag = 1'b1;
                  d.intrq    = 1'b1;
               end else if (!cache_dirty) begin
                  d.intrq = 1'b1;
               end else begin
                  d.state       = afc_pkg::S_FLUSH;
                  d.flush_start = 1'b1;
               end
            end else begin
               d.state      = afc_pkg::S_EXEC;
               d.exec_start = 1'b1;
            end
         end
      end

      case (q.state)
         // Idle keeps whatever state the command decode above chose
         afc_pkg::S_IDLE: begin
         end
         afc_pkg::S_EXEC: begin
            if (exec_done) begin
               d.state    = afc_pkg::S_IDLE;
               d.error    = exec_err & cmd_info[7:0];
               d.err_flag = |(exec_err & cmd_info[7:0]);
               d.intrq    = 1'b1;
            end
         end
         afc_pkg::S_FLUSH: begin
            // Failure is final only after the back end has run its retries
            if (flush_fail) begin
               d.state          = afc_pkg::S_IDLE;
               d.error          = flush_err & flush_info[7:0];
               d.err_flag       = 1'b1;
               d.intrq          = 1'b1;
               d.tf.sector      = fail_lba[7:0];
               d.tf.cyl_lo      = fail_lba[15:8];
               d.tf.cyl_hi      = fail_lba[23:16];
               d.tf.dev_head    = {q.tf.dev_head[7:4], fail_lba[27:24]};
               d.cache_drop     = 1'b1;
            end else if (flush_done) begin
               d.state = afc_pkg::S_IDLE;
               d.intrq = 1'b1;
            end
         end
         default: begin
            d.state = afc_pkg::S_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '{state: afc_pkg::S_IDLE,
                tf: '{features: afc_pkg::REG_RST, count: afc_pkg::REG_RST,
                      sector: afc_pkg::REG_RST, cyl_lo: afc_pkg::REG_RST,
                      cyl_hi: afc_pkg::REG_RST, dev_head: afc_pkg::REG_RST},
                cmd: afc_pkg::REG_RST, error: afc_pkg::REG_RST, err_flag: 1'b0,
                intrq: 1'b0, rdata: afc_pkg::RD_IDLE, exec_start: 1'b0,
                flush_start: 1'b0, cache_drop: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign reg_rdata   = q.rdata;
   assign intrq       = q.intrq;
   assign exec_start  = q.exec_start;
   assign exec_code   = q.cmd;
   assign task_file   = q.tf;
   assign flush_start = q.flush_start;
   assign cache_drop  = q.cache_drop;

   // ==========================================================
   // Self-monitoring data; the failure decision stays with the host
   afc_smart_mem #(
      .AW (afc_pkg::SM_AW)
   ) u_smart (
      .clk     (clk),
      .sys_rst (sys_rst),
      .fill    (smart_fill),
      .rd      (smart_rd),
      .rd_sel  (smart_sel),
      .rd_addr (smart_addr),
      .rd_data (smart_rdata)
   );

endmodule

// >>> afc_cmd_monitor.sv
/*
 * Port checker for the command block.
 * Assumes it is bound onto afc_cmd_block, one clock domain.
 */
`timescale 1ns/1ps

module afc_cmd_monitor (
   // Clock and reset
   input wire logic                         clk,
   input wire logic                         sys_rst,
   // Host port
   input wire logic [afc_pkg::ADDR_W-1:0]   reg_addr,
   input wire logic                         reg_wr,
   input wire logic                         reg_rd,
   input wire logic [7:0]                   reg_wdata,
   input wire logic                         intrq,
   input wire logic                         drive_ready,
   // Back end
   input wire logic                         exec_start,
   input wire logic                         exec_done,
   input wire logic                         cache_dirty,
   input wire logic                         flush_start,
   input wire logic                         flush_done,
   input wire logic                         flush_fail,
   input wire logic [27:0]                  fail_lba,
   input wire logic                         cache_drop,
   input wire afc_pkg::afc_taskfile_s       task_file
);
   // ==========================================================
   // Busy tracking from the start and completion pulses
   logic fl_q;
   logic ex_q;
   logic cmd_w;
   assign cmd_w = reg_wr && reg_addr == afc_pkg::A_CMD_STAT;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         fl_q <= 1'b0;
         ex_q <= 1'b0;
      end else begin
         fl_q <= (flush_start | fl_q) & ~flush_done & ~flush_fail;
         ex_q <= (exec_start | ex_q) & ~exec_done;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ==========================================================
   // Sequences
   sequence s_idle;
      !fl_q && !ex_q && !flush_start && !exec_start;
   endsequence
   sequence s_flush_req;
      s_idle ##0 (cmd_w && reg_wdata == afc_pkg::C_FLUSH && task_file.dev_head[4] == 1'b0
                  && drive_ready && cache_dirty);
   endsequence
   sequence s_fail;
      (fl_q || flush_start) && flush_fail;
   endsequence

   // ==========================================================
   // Assertions
   chk_flush_starts: assert property (s_flush_req |=> flush_start ##1 !flush_start)
      else $error("flush command did not start one flush");
   chk_fail_posts: assert property (s_fail |=> cache_drop && intrq
      && {task_file.dev_head[3:0], task_file.cyl_hi, task_file.cyl_lo, task_file.sector}
         == $past(fail_lba))
      else $error("flush failure not posted");
   chk_drop_cause: assert property (cache_drop |-> $past((fl_q || flush_start) && flush_fail))
      else $error("cache drop without flush failure");
   chk_done_irq: assert property ((fl_q || flush_start) && flush_done && !flush_fail
      |=> intrq && !cache_drop)
      else $error("flush completion not signalled");
   chk_irq_cause: assert property ($rose(intrq) |-> $past(cmd_w)
      || $past((fl_q || flush_start) && (flush_done || flush_fail))
      || $past((ex_q || exec_start) && exec_done))
      else $error("interrupt without completion");
   chk_unready_gate: assert property (cmd_w && !drive_ready
      && reg_wdata != afc_pkg::C_DIAG && reg_wdata != afc_pkg::C_INIT_PARAM
      |=> !exec_start && !flush_start)
      else $error("command started while not ready");
   chk_start_pulse: assert property ((exec_start || flush_start) |=> !(exec_start || flush_start))
      else $error("start pulse longer than one cycle");
   chk_busy_norestart: assert property ((fl_q && !flush_done && !flush_fail)[*2] |-> !flush_start)
      else $error("flush restarted while busy");
   chk_status_clear: assert property (reg_rd && reg_addr == afc_pkg::A_CMD_STAT && !reg_wr
      && !flush_done && !flush_fail && !exec_done |=> !intrq)
      else $error("status read did not clear interrupt");
endmodule

// >>> afc_host_model.sv
/*
 * Host adapter model driving the command block registers.
 * Assumes reads answer one cycle after the strobe edge.
 */
`timescale 1ns/1ps

module afc_host_model (
   // Clock
   input wire logic                         clk,
   // Register port
   output logic      [afc_pkg::ADDR_W-1:0]  reg_addr = '0,
   output logic                             reg_wr = 1'b0,
   output logic                             reg_rd = 1'b0,
   output logic      [7:0]                  reg_wdata = 8'h00,
   input wire logic  [7:0]                  reg_rdata
);
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      // Released data lines show garbage, not the old value
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask

   // Poll status until not busy or 500 reads have passed, then issue the command
   task automatic cmd(input logic [7:0] c);
      logic [7:0] s;
      s = 8'h80;
      for (int n = 0; n < 500 && s[afc_pkg::ST_BSY]; n++) begin
         rd(afc_pkg::A_CMD_STAT, s);
      end
      wr(afc_pkg::A_CMD_STAT, c);
   endtask
endmodule

// >>> afc_tb.sv
/*
 * Self-checking bench for the command block.
 * Assumes the host model and the bench share the 50 MHz clock.
 */
`timescale 1ns/1ps

module tb;
   logic                          clk = 1'b0;
   logic                          sys_rst = 1'b1;
   logic [afc_pkg::ADDR_W-1:0]    reg_addr;
   logic                          reg_wr, reg_rd, intrq, exec_start, flush_start, cache_drop;
   logic [7:0]                    reg_wdata, reg_rdata, exec_code, smart_rdata, d;
   afc_pkg::afc_taskfile_s        task_file;
   logic                          drive_ready = 1'b1, cache_dirty = 1'b0, write_fault = 1'b0;
   logic                          exec_done = 1'b0, flush_done = 1'b0, flush_fail = 1'b0;
   logic [7:0]                    exec_err = 8'h00, flush_err = 8'h00;
   logic [27:0]                   fail_lba = 28'h0;
   afc_pkg::afc_smart_wr_s        smart_fill = '0;
   logic                          smart_rd = 1'b0, smart_sel = 1'b0;
   logic [8:0]                    smart_addr = 9'h0;
   int                            n_mismatch = 0, num_checks = 0;

   always #10 clk = ~clk;

   afc_cmd_block afc_cmd_block_inst (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .intrq, .drive_ready, .write_fault, .exec_start, .exec_code,
      .task_file, .exec_done, .exec_err, .cache_dirty, .flush_start, .flush_done, .flush_fail,
      .flush_err, .fail_lba, .cache_drop, .smart_fill, .smart_rd, .smart_sel, .smart_addr,
      .smart_rdata);
   afc_host_model afc_host_model_inst (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata);

   // ==========================================================
   // Helpers
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task r(input logic [9:0] a, input logic [7:0] e, input string nm);
      afc_host_model_inst.rd(a, d);
      chk(nm, d, e);
   endtask
   task c(input logic [7:0] code);
      afc_host_model_inst.cmd(code);
   endtask
   // Back-end pulse: 0 flush done, 1 flush failed, 2 command done
   task bp(input int k);
      @(posedge clk);
      #1;
      {flush_done, flush_fail, exec_done} = {k == 0, k == 1, k == 2};
      @(posedge clk);
      #1;
      {flush_done, flush_fail, exec_done} = 3'b000;
   endtask
   task results;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task t_reset;
      for (int a = 'h1f0; a <= 'h1f7; a++) begin
         r(a[9:0], (a == 'h1f7) ? 8'h40 : 8'h00, "reset reg");
      end
   endtask
   task t_flush;
      c(8'he7);
      chk("clean irq", {intrq, flush_start}, 8'h02);
      r(10'h1f7, 8'h40, "clean status");
      afc_host_model_inst.wr(10'h1f3, 8'h33);
      afc_host_model_inst.wr(10'h1f1, 8'h99);
      cache_dirty = 1'b1;
      c(8'he7);
      chk("flush start", {7'h0, flush_start}, 8'h01);
      r(10'h1f7, 8'hc0, "busy status");
      afc_host_model_inst.wr(10'h1f3, 8'h55);
      bp(0);
      chk("done irq", {7'h0, intrq}, 8'h01);
      r(10'h1f7, 8'h40, "done status");
      r(10'h1f3, 8'h33, "busy write");
   endtask
   task t_fail;
      fail_lba = 28'h3a5c7e1;
      flush_err = 8'hff;
      c(8'he7);
      bp(1);
      chk("drop", {cache_drop, intrq}, 8'h03);
      r(10'h1f7, 8'h41, "fail status");
      r(10'h1f1, 8'h14, "fail error");
      r(10'h1f3, 8'he1, "fail sector");
      r(10'h1f4, 8'hc7, "fail cyl lo");
      r(10'h1f5, 8'ha5, "fail cyl hi");
      r(10'h1f6, 8'h03, "fail head");
      c(8'he7);
      chk("resume", {7'h0, flush_start}, 8'h01);
      bp(0);
      afc_host_model_inst.wr(10'h1f6, 8'h10);
      c(8'he7);
      chk("deselect", {intrq, flush_start}, 8'h00);
      afc_host_model_inst.wr(10'h1f6, 8'h00);
   endtask
   task automatic t_errs;
      logic [7:0] cd [8] = '{8'hc8, 8'hca, 8'h20, 8'h40, 8'h3c, 8'h30, 8'h10, 8'h90};
      logic [7:0] ex [8] = '{8'hc0, 8'h80, 8'h40, 8'h40, 8'h40, 8'h00, 8'h02, 8'hc2};
      exec_err = 8'hc2;
      for (int i = 0; i < 8; i++) begin
         c(cd[i]);
         chk("exec start", exec_start ? exec_code : 8'h00, cd[i]);
         bp(2);
         r(10'h1f1, ex[i], "posted error");
         r(10'h1f7, {7'h20, ex[i] != 8'h00}, "posted status");
      end
      write_fault = 1'b1;
      r(10'h1f7, 8'h41, "fault masked");
      exec_err = 8'h00;
      c(8'h01);
      chk("unknown", {intrq, exec_start}, 8'h02);
      r(10'h1f1, 8'h04, "unknown error");
      r(10'h1f7, 8'h61, "fault shown");
      write_fault = 1'b0;
      drive_ready = 1'b0;
      c(8'h20);
      r(10'h1f7, 8'h01, "unready abort");
      c(8'h91);
      chk("unready init", {7'h0, exec_start}, 8'h01);
      bp(2);
      r(10'h1f7, 8'h00, "unready done");
      drive_ready = 1'b1;
   endtask
   task sr(input logic sel, input logic [8:0] a, input logic [7:0] e);
      @(posedge clk);
      #1;
      {smart_fill.wr, smart_rd, smart_sel, smart_addr} = {2'b01, sel, a};
      @(posedge clk);
      #1;
      smart_rd = 1'b0;
      chk("smart byte", smart_rdata, e);
   endtask
   task t_smart;
      logic [7:0] sum;
      sum = 8'h00;
      for (int i = 0; i < 512; i++) begin
         @(posedge clk);
         #1;
         smart_fill = '{wr: 1'b1, sel: 1'b0, addr: i[8:0], data: i[7:0] ^ 8'h5a};
         sum = (i < 511) ? sum + (i[7:0] ^ 8'h5a) : sum;
      end
      sr(1'b0, 9'h1ff, 8'h00 - sum);
      sr(1'b0, 9'h005, 8'h5f);
      sr(1'b1, 9'h1ff, 8'h00);
      sr(1'b1, 9'h005, 8'h00);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_reset;
      t_flush;
      t_fail;
      t_errs;
      t_smart;
      results;
   end

   // Whole run needs under 2000 cycles
   initial begin
      #400000;
      n_mismatch++;
      results;
   end
endmodule

bind afc_cmd_block afc_cmd_monitor afc_cmd_monitor_inst (.clk, .sys_rst, .reg_addr, .reg_wr,
   .reg_rd, .reg_wdata, .intrq, .drive_ready, .exec_start, .exec_done, .cache_dirty,
   .flush_start, .flush_done, .flush_fail, .fail_lba, .cache_drop, .task_file);
